// [cml_regs.vh]
// register map, field positions and sizes of the logic cell fabric
// assumes byte addresses on a 16-bit AXI4-Lite address, 32-bit words
`ifndef CML_REGS_VH
`define CML_REGS_VH
// small registers
`define CML_SIG_OFF      16'h0000
`define CML_FUSE_OFF     16'h0004
`define CML_CTRL_OFF     16'h0008
`define CML_STLO_OFF     16'h0010
`define CML_STHI_OFF     16'h0014
`define CML_PINLO_OFF    16'h0018
`define CML_PINHI_OFF    16'h001c
`define CML_SMALL_END    16'h0020
// configuration arrays
`define CML_CFG_BASE     16'h0400
`define CML_CFG_END      16'h0600
`define CML_SW_BASE      16'h0800
`define CML_SW_END       16'h0a80
`define CML_PT_BASE      16'h4000
`define CML_PT_END       16'h6000
// reset values
`define CML_SIG_RST      16'h0000
`define CML_CFG_RST      32'h00000000
// cell word a fields
`define CML_A_SUM        0
`define CML_A_CASC       5
`define CML_A_XOR        6
`define CML_A_DSRC       8
`define CML_A_MODE       10
`define CML_A_CLK        13
`define CML_A_CE         15
`define CML_A_CLR        16
`define CML_A_PRE        18
`define CML_A_OREG       19
`define CML_A_FREG       20
`define CML_A_IO         21
`define CML_A_OEINV      23
`define CML_A_OESRC      24
// cell word b fields, 3-bit term indices and 4-bit enable index
`define CML_B_XPT        0
`define CML_B_DPT        3
`define CML_B_CPT        6
`define CML_B_EPT        9
`define CML_B_RPT        12
`define CML_B_PPT        15
`define CML_B_FPT        18
`define CML_B_OEIDX      21
// sizes
`define CML_CASC_MAX     4'd8
`define CML_BUS_LAST     8'd133
`endif

// [cml_top.v]
// 64-cell programmable logic fabric emulated on one clock, with config
// over AXI4-Lite; pins and cell clocks are sampled on aclk
`timescale 1ns/10ps
`include "cml_regs.vh"
module cml_top (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi write address and data
	input  wire [15:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi read
	input  wire [15:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// dedicated inputs
	input  wire [2:0]  global_clock_inputs,
	input  wire        global_clear_input,
	input  wire [1:0]  oe_pins,
	// i/o pins
	input  wire [63:0] io_in,
	input  wire [63:0] io_driven,
	output wire [63:0] io_out,
	output wire [63:0] io_oe
);
	localparam [2:0] RG_NONE = 3'd0;
	localparam [2:0] RG_SMALL = 3'd1;
	localparam [2:0] RG_CFG = 3'd2;
	localparam [2:0] RG_SW = 3'd3;
	localparam [2:0] RG_PT = 3'd4;
	localparam [1:0] OKAY = 2'b00;
	localparam [1:0] SLVERR = 2'b10;
	localparam [1:0] DECERR = 2'b11;

	function [2:0] cml_region;
		input [15:0] a;
		begin
			if (a < `CML_SMALL_END)
				cml_region = RG_SMALL;
			else if (a >= `CML_CFG_BASE && a < `CML_CFG_END)
				cml_region = RG_CFG;
			else if (a >= `CML_SW_BASE && a < `CML_SW_END)
				cml_region = RG_SW;
			else if (a >= `CML_PT_BASE && a < `CML_PT_END && a[6:4] < 3'd5)
				cml_region = RG_PT;
			else
				cml_region = RG_NONE;
		end
	endfunction

	function [8:0] cml_pt_index;
		input [15:0] a;
		begin
			cml_pt_index = {1'b0, a[12:7], 2'b00} + {3'b000, a[12:7]}
				+ {6'b000000, a[6:4]};
		end
	endfunction

	function [31:0] cml_strb;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  s;
		integer b;
		begin
			cml_strb = old;
			for (b = 0; b < 4; b = b + 1)
				if (s[b])
					cml_strb[8*b +: 8] = nw[8*b +: 8];
		end
	endfunction

	function cml_pick;
		input [4:0] v;
		input [2:0] s;
		begin
			cml_pick = (s < 3'd5) ? v[s] : 1'b0;
		end
	endfunction

	// next state of the storage element; k is the reset-side term
	function cml_ff;
		input [2:0] m;
		input       q;
		input       d;
		input       x;
		input       k;
		begin
			case (m)
				3'd0: cml_ff = d;
				3'd1: cml_ff = q ^ x;
				3'd2: cml_ff = (x & ~q) | (~k & q);
				3'd3: cml_ff = k ? 1'b0 : (x ? 1'b1 : q);
				default: cml_ff = q;
			endcase
		end
	endfunction

	reg [31:0] cfg_q [0:127];
	reg [7:0]  sw_q  [0:159];
	reg [43:0] ptt_q [0:319];
	reg [43:0] ptc_q [0:319];
	reg [15:0] sig_q;
	reg        fuse_q;
	reg        keeper_q;
	reg        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	reg        aw_v_q, w_v_q;
	reg [15:0] awaddr_q;
	reg [31:0] wdata_q, rdata_q;
	reg [3:0]  wstrb_q;
	reg [1:0]  bresp_q, rresp_q;
	reg [31:0] rd_data, wr_old;
	reg [1:0]  rd_resp;
	integer    k;

	wire [63:0]  state_w, cell_out_w, pin_seen_w, fb_w, fold_w;
	wire [63:0]  io_out_w, io_oe_w, sum_w;
	wire [255:0] depth_w;
	wire [255:0] gbus;
	wire [159:0] sw_bus;
	wire [2:0]   aw_rgn = cml_region(awaddr_q);
	wire [2:0]   ar_rgn = cml_region(s_axi_araddr);
	wire [8:0]   aw_pti = cml_pt_index(awaddr_q);
	wire [8:0]   ar_pti = cml_pt_index(s_axi_araddr);
	wire [31:0]  wr_new = cml_strb(wr_old, wdata_q, wstrb_q);
	wire [1:0]   wr_resp = (aw_rgn == RG_NONE) ? DECERR : OKAY;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign io_out = io_out_w;
	assign io_oe = io_oe_w;

	// global bus: pins 0..63, feedbacks 64..127, dedicated 128..133
	assign gbus = {122'h0, oe_pins, global_clear_input,
		global_clock_inputs, fb_w, pin_seen_w};

	genvar i, p, s;
	generate
		for (s = 0; s < 160; s = s + 1) begin : g_sw
			assign sw_bus[s] = (sw_q[s] <= `CML_BUS_LAST) ?
				gbus[sw_q[s]] : 1'b0;
		end

		for (i = 0; i < 64; i = i + 1) begin : g_cell
			reg         st_q, ck_q, fb_q, fold_q, out_q, oe_q, keep_q;
			wire [31:0] ca = cfg_q[2*i];
			wire [31:0] cb = cfg_q[2*i+1];
			wire [43:0] pin_in = {fold_w[4*(i/4) +: 4],
				sw_bus[40*(i/16) +: 40]};
			wire [4:0]  pt;
			wire        casc_in, use_casc, xor_o, d_o, clk, ce_ok;
			wire        clr, pre, oe_sel, x_in;
			wire [3:0]  prev_depth;
			wire [2:0]  mode = ca[`CML_A_MODE +: 3];
			wire [1:0]  csrc = ca[`CML_A_CLK +: 2];
			wire [1:0]  xmode = ca[`CML_A_XOR +: 2];
			wire [1:0]  dsrc = ca[`CML_A_DSRC +: 2];
			wire [1:0]  iomode = ca[`CML_A_IO +: 2];
			wire [1:0]  oesrc = ca[`CML_A_OESRC +: 2];
			wire [3:0]  oeidx = cb[`CML_B_OEIDX +: 4];
			for (p = 0; p < 5; p = p + 1) begin : g_pt
				assign pt[p] = &(~ptt_q[i*5+p] | pin_in)
					& &(~ptc_q[i*5+p] | ~pin_in);
			end
			if (i % 16 == 0) begin : g_head
				assign casc_in = 1'b0;
				assign prev_depth = 4'd0;
			end else begin : g_link
				assign casc_in = sum_w[i-1];
				assign prev_depth = depth_w[4*(i-1) +: 4];
			end
			// chain limited to eight cells of five terms
			assign use_casc = ca[`CML_A_CASC]
				&& (prev_depth < `CML_CASC_MAX);
			assign depth_w[4*i +: 4] = use_casc ?
				prev_depth + 4'd1 : 4'd1;
			assign sum_w[i] = |(pt & ca[`CML_A_SUM +: 5])
				| (use_casc & casc_in);
			assign x_in = (xmode == 2'd2) ?
				cml_pick(pt, cb[`CML_B_XPT +: 3]) :
				(xmode == 2'd1);
			assign xor_o = sum_w[i] ^ x_in;
			assign d_o = (dsrc == 2'd1) ? cml_pick(pt, cb[`CML_B_DPT +: 3]) :
				(dsrc == 2'd2) ? pin_seen_w[i] : xor_o;
			assign clk = (csrc == 2'd3) ? cml_pick(pt, cb[`CML_B_CPT +: 3])
				: global_clock_inputs[csrc];
			assign ce_ok = !(ca[`CML_A_CE] && csrc != 2'd3)
				|| cml_pick(pt, cb[`CML_B_EPT +: 3]);
			assign clr = (ca[`CML_A_CLR] & global_clear_input)
				| (ca[`CML_A_CLR+1] &
				cml_pick(pt, cb[`CML_B_RPT +: 3]));
			assign pre = ca[`CML_A_PRE]
				& cml_pick(pt, cb[`CML_B_PPT +: 3]);
			assign cell_out_w[i] = ca[`CML_A_OREG] ? st_q : xor_o;
			assign oe_sel = ((oesrc == 2'd0) ? oe_pins[0] :
				(oesrc == 2'd1) ? oe_pins[1] :
				(oesrc == 2'd2) ? pin_seen_w[(i/16)*16 + oeidx] :
				cell_out_w[(i/16)*16 + oeidx]) ^ ca[`CML_A_OEINV];
			always @(posedge aclk) begin
				if (!aresetn) begin
					st_q <= 1'b0;
					ck_q <= 1'b0;
					fb_q <= 1'b0;
					fold_q <= 1'b0;
					out_q <= 1'b0;
					oe_q <= 1'b0;
				end else begin
					ck_q <= clk;
					if (clr)
						st_q <= 1'b0;
					else if (pre)
						st_q <= 1'b1;
					else if (mode == 3'd4) begin
						if (clk)
							st_q <= d_o;
					end else if (clk && !ck_q && ce_ok)
						st_q <= cml_ff(mode, st_q, d_o, xor_o,
							cml_pick(pt, cb[`CML_B_DPT +: 3]));
					// feedback stays live whatever the pin mode
					fb_q <= ca[`CML_A_FREG] ? st_q : xor_o;
					fold_q <= ~cml_pick(pt, cb[`CML_B_FPT +: 3]);
					out_q <= cell_out_w[i];
					oe_q <= (iomode == 2'd1) ? 1'b1 :
						(iomode == 2'd2) ? oe_sel : 1'b0;
				end
			end
			always @(posedge aclk) begin
				if (!aresetn)
					keep_q <= 1'b0;
				else
					keep_q <= pin_seen_w[i];
			end
			assign pin_seen_w[i] = oe_q ? out_q : io_driven[i] ? io_in[i] :
				(keeper_q & keep_q);
			assign state_w[i] = st_q;
			assign fb_w[i] = fb_q;
			assign fold_w[i] = fold_q;
			assign io_out_w[i] = out_q;
			assign io_oe_w[i] = oe_q;
		end
	endgenerate

	// old word of the write target, merged with the strobes
	always @* begin
		wr_old = 32'h0;
		case (aw_rgn)
			RG_SMALL: begin
				if (awaddr_q[15:2] == `CML_SIG_OFF >> 2)
					wr_old = {16'h0, sig_q};
				else if (awaddr_q[15:2] == `CML_CTRL_OFF >> 2)
					wr_old = {31'h0, keeper_q};
			end
			RG_CFG: wr_old = cfg_q[awaddr_q[8:2]];
			RG_SW: wr_old = {24'h0, sw_q[awaddr_q[9:2]]};
			RG_PT: begin
				case (awaddr_q[3:2])
					2'd0: wr_old = ptt_q[aw_pti][31:0];
					2'd1: wr_old = {20'h0, ptt_q[aw_pti][43:32]};
					2'd2: wr_old = ptc_q[aw_pti][31:0];
					default: wr_old = {20'h0, ptc_q[aw_pti][43:32]};
				endcase
			end
			default: wr_old = 32'h0;
		endcase
	end

	always @* begin
		rd_data = 32'h0;
		rd_resp = OKAY;
		case (ar_rgn)
			RG_SMALL: begin
				case ({s_axi_araddr[15:2], 2'b00})
					`CML_SIG_OFF: rd_data = {16'h0, sig_q};
					`CML_FUSE_OFF: rd_data = {31'h0, fuse_q};
					`CML_CTRL_OFF: rd_data = {31'h0, keeper_q};
					`CML_STLO_OFF: rd_data = state_w[31:0];
					`CML_STHI_OFF: rd_data = state_w[63:32];
					`CML_PINLO_OFF: rd_data = pin_seen_w[31:0];
					`CML_PINHI_OFF: rd_data = pin_seen_w[63:32];
					default: rd_data = 32'h0;
				endcase
			end
			RG_CFG, RG_SW, RG_PT: begin
				if (fuse_q)
					rd_resp = SLVERR;
				else if (ar_rgn == RG_CFG)
					rd_data = cfg_q[s_axi_araddr[8:2]];
				else if (ar_rgn == RG_SW)
					rd_data = {24'h0, sw_q[s_axi_araddr[9:2]]};
				else begin
					case (s_axi_araddr[3:2])
						2'd0: rd_data = ptt_q[ar_pti][31:0];
						2'd1: rd_data = {20'h0, ptt_q[ar_pti][43:32]};
						2'd2: rd_data = ptc_q[ar_pti][31:0];
						default: rd_data = {20'h0, ptc_q[ar_pti][43:32]};
					endcase
				end
			end
			default: rd_resp = DECERR;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			aw_v_q <= 1'b0;
			w_v_q <= 1'b0;
			awaddr_q <= 16'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bresp_q <= OKAY;
			rresp_q <= OKAY;
			rdata_q <= 32'h0;
			sig_q <= `CML_SIG_RST;
			fuse_q <= 1'b0;
			keeper_q <= 1'b0;
			for (k = 0; k < 128; k = k + 1)
				cfg_q[k] <= `CML_CFG_RST;
			for (k = 0; k < 160; k = k + 1)
				sw_q[k] <= 8'h00;
			for (k = 0; k < 320; k = k + 1) begin
				ptt_q[k] <= 44'h0;
				ptc_q[k] <= 44'h0;
			end
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awaddr_q <= s_axi_awaddr;
				aw_v_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_v_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (aw_v_q && w_v_q && !bvalid_q) begin
				aw_v_q <= 1'b0;
				w_v_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_resp;
				case (aw_rgn)
					RG_SMALL: begin
						if (awaddr_q[15:2] == `CML_SIG_OFF >> 2)
							sig_q <= wr_new[15:0];
						else if (awaddr_q[15:2] == `CML_CTRL_OFF >> 2)
							keeper_q <= wr_new[0];
						else if (awaddr_q[15:2] == `CML_FUSE_OFF >> 2
							&& wstrb_q[0] && wdata_q[0])
							fuse_q <= 1'b1;
					end
					RG_CFG: cfg_q[awaddr_q[8:2]] <= wr_new;
					RG_SW: sw_q[awaddr_q[9:2]] <= wr_new[7:0];
					RG_PT: begin
						case (awaddr_q[3:2])
							2'd0: ptt_q[aw_pti][31:0] <= wr_new;
							2'd1: ptt_q[aw_pti][43:32] <= wr_new[11:0];
							2'd2: ptc_q[aw_pti][31:0] <= wr_new;
							default: ptc_q[aw_pti][43:32] <= wr_new[11:0];
						endcase
					end
					default: bresp_q <= wr_resp;
				endcase
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
			if (s_axi_arvalid && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= rd_resp;
			end
			if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end
endmodule

// [cml_top_sva.sv]
// port checker for cml_top: axi handshakes, answers and reset state
// assumes a bind onto every cml_top instance
`timescale 1ns/10ps
module cml_top_sva (
	// clock and reset
	input wire        aclk,
	input wire        aresetn,
	// axi
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// pins
	input wire [63:0] io_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready) else $error("awready stayed high");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid && !s_axi_wready
		##1 s_axi_bvalid) else $error("write answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_b_end: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write not closed");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data moved");
	a_r_end: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready) else $error("read not closed");
	a_unmap_dec: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 16'h0100 |=> s_axi_rresp == 2'b11 &&
		s_axi_rdata == 32'h0) else $error("unmapped read answered");
	a_sig_width: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[15:2] == 14'h0 |=>
		s_axi_rdata[31:16] == 16'h0) else $error("signature too wide");
	a_rst_state: assert property (disable iff (1'b0)
		!aresetn |=> s_axi_arready && s_axi_awready && !s_axi_bvalid &&
		!s_axi_rvalid && io_oe == 64'h0) else $error("reset state wrong");
endmodule
bind cml_top cml_top_sva cml_top_sva_inst (.*);

// [cml_board.sv]
// board logic on the pins: drives or releases each pin on command
// assumes the bench commands it just after rising aclk edges
`timescale 1ns/10ps
module cml_board (
	// clock
	input  wire        aclk,
	// commands
	input  wire [63:0] drive_val,
	input  wire [63:0] drive_en,
	// pins
	output wire [63:0] io_in,
	output wire [63:0] io_driven
);
	reg [63:0] last_q;
	initial last_q = 64'h0;
	always @(posedge aclk) begin
		last_q <= (drive_en & drive_val) | (~drive_en & last_q);
	end
	// released pins float: show the inverse of the last level
	assign io_in = (drive_en & drive_val) | (~drive_en & ~last_q);
	assign io_driven = drive_en;
endmodule

// [tb_cml_top.sv]
// self-checking bench for cml_top over axi4-lite and the pins
// assumes cml_regs.vh map and the board model cml_board
`timescale 1ns/10ps
`include "cml_regs.vh"
module tb_cml_top;
	logic        aclk, aresetn, pin_chk;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, sig;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, oe_pins;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, global_clear_input;
	logic [2:0]  global_clock_inputs;
	logic [63:0] io_in, io_driven, io_out, io_oe, drive_val, drive_en;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic [7:0]  pq[$];
	logic [7:0]  p;
	integer      n_fail, tests_run, seed, i;

	cml_top cml_top_inst (.*);
	cml_board cml_board_inst (.*);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task tally(input logic [33:0] g, input logic [33:0] x);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task cmp_r(input logic [33:0] g, input logic [33:0] x);
		tally(g, x);
	endtask
	task cmp_b(input logic [1:0] g, input logic [1:0] x);
		tally({32'h0, g}, {32'h0, x});
	endtask
	task cmp_p(input logic g, input logic x);
		tally({33'h0, g}, {33'h0, x});
	endtask

	task conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// settle, then have the watcher look at one pin output or enable
	task pin(input logic [5:0] n, input logic oe, input logic v);
		repeat (8) @(posedge aclk);
		pq.push_back({oe, n, v});
		pin_chk <= 1'b1;
		@(posedge aclk);
		pin_chk <= 1'b0;
	endtask

	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_r({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp_b(s_axi_bresp, bq.pop_front());
		if (pin_chk) begin
			p = pq.pop_front();
			cmp_p(p[7] ? io_oe[p[6:1]] : io_out[p[6:1]], p[0]);
		end
	end

	initial begin
		repeat (6000) @(posedge aclk);
		$display("watchdog expired");
		n_fail++;
		conclude;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, pin_chk} = 4'h0;
		{s_axi_arvalid, s_axi_rready, global_clear_input} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
		s_axi_wstrb = 4'hf;
		{oe_pins, global_clock_inputs} = 5'h0;
		{drive_val, drive_en} = 128'h0;
		n_fail = 0;
		tests_run = 0;
		seed = 13948;
		aresetn = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CML_SIG_OFF, 32'h0, 2'b00);
		rd(`CML_FUSE_OFF, 32'h0, 2'b00);
		rd(`CML_CFG_BASE, `CML_CFG_RST, 2'b00);
		rd(16'h0100, 32'h0, 2'b11);
		wr(16'h0100, 32'h1, 2'b11);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			sig = $random(seed);
			wr(`CML_SIG_OFF, sig, 2'b00);
			rd(`CML_SIG_OFF, {16'h0, sig[15:0]}, 2'b00);
		end
		$display("test signature done");
		oe_pins <= 2'b01;
		wr(`CML_CFG_BASE, 32'h0020_0001, 2'b00);
		pin(6'd0, 1'b1, 1'b1);
		pin(6'd0, 1'b0, 1'b1);
		wr(`CML_CFG_BASE, 32'h0020_0041, 2'b00);
		pin(6'd0, 1'b0, 1'b0);
		wr(`CML_CFG_BASE, 32'h00c0_0041, 2'b00);
		pin(6'd0, 1'b1, 1'b0);
		oe_pins <= 2'b00;
		pin(6'd0, 1'b1, 1'b1);
		$display("test sum and polarity done");
		wr(`CML_SW_BASE, 32'h1, 2'b00);
		wr(`CML_PT_BASE, 32'h1, 2'b00);
		wr(`CML_CFG_BASE, 32'h00a0_0001, 2'b00);
		for (i = 0; i < 2; i++) begin
			drive_en <= 64'h2;
			drive_val <= {62'h0, ~i[0], 1'b0};
			pin(6'd0, 1'b0, ~i[0]);
		end
		$display("test switch matrix done");
		wr(`CML_CFG_BASE, 32'h0, 2'b00);
		for (i = 0; i < 2; i++) begin
			wr(`CML_CTRL_OFF, i, 2'b00);
			drive_en <= 64'h22;
			drive_val <= 64'h20;
			repeat (4) @(posedge aclk);
			drive_en <= 64'h2;
			rd(`CML_PINLO_OFF, i ? 32'h20 : 32'h0, 2'b00);
		end
		$display("test keeper done");
		wr(`CML_CFG_BASE + 16'h8, 32'h0029_0001, 2'b00);
		rd(`CML_STLO_OFF, 32'h0, 2'b00);
		for (i = 1; i < 3; i++) begin
			global_clock_inputs <= i[2:0] ^ 3'b011;
			repeat (4) @(posedge aclk);
			global_clock_inputs <= 3'b000;
			rd(`CML_STLO_OFF, i == 2 ? 32'h2 : 32'h0, 2'b00);
			global_clear_input <= 1'b1;
			repeat (3) @(posedge aclk);
			rd(`CML_STLO_OFF, 32'h0, 2'b00);
			global_clear_input <= 1'b0;
		end
		$display("test storage done");
		// toggle mode twice, then a low enable term blocks the edge
		wr(`CML_CFG_BASE + 16'h8, 32'h0029_0401, 2'b00);
		for (i = 0; i < 3; i++) begin
			if (i == 2) begin
				wr(`CML_CFG_BASE + 16'hc, 32'h0000_0a00, 2'b00);
				wr(`CML_CFG_BASE + 16'h8, 32'h0029_8401, 2'b00);
			end
			global_clock_inputs <= 3'b001;
			repeat (4) @(posedge aclk);
			global_clock_inputs <= 3'b000;
			rd(`CML_STLO_OFF, i == 0 ? 32'h2 : 32'h0, 2'b00);
		end
		// latch: follow while high, hold while low
		wr(`CML_CFG_BASE + 16'h8, 32'h0029_1001, 2'b00);
		for (i = 0; i < 3; i++) begin
			global_clock_inputs <= {2'b00, i != 1};
			if (i == 1)
				wr(`CML_CFG_BASE + 16'h8, 32'h0029_1041, 2'b00);
			repeat (4) @(posedge aclk);
			rd(`CML_STLO_OFF, i == 2 ? 32'h0 : 32'h2, 2'b00);
		end
		global_clock_inputs <= 3'b000;
		// preset term alone sets, global clear beats it
		wr(`CML_CFG_BASE + 16'h8, 32'h002d_0001, 2'b00);
		for (i = 0; i < 2; i++) begin
			global_clear_input <= i[0];
			repeat (3) @(posedge aclk);
			rd(`CML_STLO_OFF, i ? 32'h0 : 32'h2, 2'b00);
		end
		global_clear_input <= 1'b0;
		wr(`CML_CFG_BASE + 16'h8, 32'h0029_0001, 2'b00);
		$display("test modes done");
		rd(`CML_CFG_BASE + 16'h8, 32'h0029_0001, 2'b00);
		wr(`CML_FUSE_OFF, 32'h1, 2'b00);
		rd(`CML_FUSE_OFF, 32'h1, 2'b00);
		rd(`CML_CFG_BASE + 16'h8, 32'h0, 2'b10);
		rd(`CML_SIG_OFF, {16'h0, sig[15:0]}, 2'b00);
		$display("test fuse done");
		conclude;
	end
endmodule
